//--- sleep_airplane_params.svh
// Constants for the sleep and airplane mode controller.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef SLEEP_AIRPLANE_PARAMS_SVH
`define SLEEP_AIRPLANE_PARAMS_SVH

// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_FUNLEVEL 12'h004
`define OFS_STATUS 12'h008
`define OFS_SUPPLY 12'h00C
`define OFS_COMMAND 12'h010
`define OFS_ID 12'h014

// Control register fields
`define CTL_SLEEP_EN 0
`define CTL_SENSE_POL 1
`define CTL_AIRPLANE_PIN_EN 2
`define CTL_USB_MODE_LSB 3
`define CTL_USB_MODE_MSB 4
`define CTL_RESET 32'h0000_0000

// Functionality levels
`define FUN_MIN 3'h0
`define FUN_FULL 3'h1
`define FUN_AIRPLANE 3'h4

// Status fields
`define ST_ASLEEP 0
`define ST_RF_ON 1
`define ST_CARD_ON 2
`define ST_HOST_ASLEEP 3
`define ST_RING 4
`define ST_REMOTE_WAKE 5
`define ST_CMD_REJECT 6
`define ST_POSITION_ON 7

// Wake and sleep settle times
`define RING_PULSE_US 120
`define RING_PULSE_CYC ((`RING_PULSE_US * 20 + 0) / 1)
`define SUSPEND_SETTLE_US 10
`define SUSPEND_SETTLE_CYC (`SUSPEND_SETTLE_US * 20)

`endif

//--- sleep_airplane_pkg.sv
// Types for the sleep and airplane mode controller.
// Constants live in the params header.
package sleep_airplane_pkg;

	typedef enum logic [1:0] {
		USB_NONE = 2'b00,
		USB_REMOTE_WAKE = 2'b01,
		USB_RING_WAKE = 2'b10,
		USB_NO_SUSPEND = 2'b11
	} usb_mode_type;

	typedef enum logic [1:0] {
		PM_AWAKE = 2'b00,
		PM_SETTLE = 2'b01,
		PM_ASLEEP = 2'b10
	} pm_state_type;

	typedef struct packed {
		logic rfOn;
		logic cardOn;
		logic positionOn;
	} func_enables_type;

	typedef struct packed {
		logic termReady;
		logic hostSense;
		logic usbPower;
		logic airplanePin;
	} pin_inputs_type;

endpackage

//--- sleep_airplane_mode_control.sv
// Sleep, wake and functionality level control of a cellular module.
// Assumes host pins arrive asynchronously and software uses AXI4-Lite.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "sleep_airplane_params.svh"

module sleep_airplane_mode_control #(
	parameter int SUPPLY_WIDTH = 12,
	parameter logic [31:0] ID_VALUE = 32'h0000_5A5A // Arbitrary value
) (
	input wire logic sys_clk,
	input wire logic srst,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Host side pins, asynchronous
	input wire sleep_airplane_pkg::pin_inputs_type pinsIn,
	// USB core events, same clock
	input wire logic usbSuspended,
	input wire logic usbRxData,
	input wire logic reportPending,
	input wire logic powerDown,
	input wire logic networkEvent,
	input wire logic [SUPPLY_WIDTH-1:0] baseband_supply,
	// Outputs
	output logic ringIndicator,
	output logic usbRemoteWake,
	output logic asleep,
	output logic networkAccept,
	output sleep_airplane_pkg::func_enables_type funcEnables
);
	import sleep_airplane_pkg::*;

	localparam logic [15:0] RING_CYC = 16'(`RING_PULSE_CYC);
	localparam logic [15:0] SETTLE_CYC = 16'(`SUSPEND_SETTLE_CYC);

	// Register selects, one aligned word each: control, level, status, supply,
	// command, identity. Reads of the level give the effective level, so the
	// pin override is visible to software. Writes to read-only words are
	// accepted and dropped; unmapped addresses answer with a slave error (2'b10).
	localparam logic [2:0] SEL_CONTROL = 3'h0;
	localparam logic [2:0] SEL_FUNLEVEL = 3'h1;
	localparam logic [2:0] SEL_STATUS = 3'h2;
	localparam logic [2:0] SEL_SUPPLY = 3'h3;
	localparam logic [2:0] SEL_COMMAND = 3'h4;
	localparam logic [2:0] SEL_ID = 3'h5;
	localparam logic [2:0] SEL_NONE = 3'h7;

	// Decode a word address to a register select
	function automatic logic [2:0] regSel(input logic [11:0] addr);
		case (addr)
			`OFS_CONTROL: regSel = SEL_CONTROL;
			`OFS_FUNLEVEL: regSel = SEL_FUNLEVEL;
			`OFS_STATUS: regSel = SEL_STATUS;
			`OFS_SUPPLY: regSel = SEL_SUPPLY;
			`OFS_COMMAND: regSel = SEL_COMMAND;
			`OFS_ID: regSel = SEL_ID;
			default: regSel = SEL_NONE;
		endcase
	endfunction

	// Byte lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	// Only the three defined levels are accepted; others leave the level alone
	function automatic logic legalLevel(input logic [2:0] level);
		legalLevel = (level == `FUN_MIN) || (level == `FUN_FULL) || (level == `FUN_AIRPLANE);
	endfunction

	// Three-stage synchronisers; a change counts when stages two and three agree
	// Resetting to ones matches the pull-ups, so no false wake follows reset
	pin_inputs_type pinMeta, pinSync2, pinSync3, pinStable;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pinMeta <= '1; // Pull-up view of open lines
			pinSync2 <= '1;
			pinSync3 <= '1;
		end else begin
			pinMeta <= pinsIn;
			pinSync2 <= pinMeta;
			pinSync3 <= pinSync2;
		end
	end

	// Filtered level, updated only when the last two stages agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pinStable <= '1; // Open terminal-ready reads high
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (pinSync2[i] == pinSync3[i]) begin
					pinStable[i] <= pinSync3[i];
				end
			end
		end
	end

	// Registers
	logic [31:0] control_reg;
	logic [2:0] funLevel_reg;
	logic cmdReject_reg;
	logic [31:0] rdata_reg;
	logic awTaken, wTaken;
	logic [11:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic doWrite;

	wire logic sleepEn = control_reg[`CTL_SLEEP_EN];
	wire logic sensePol = control_reg[`CTL_SENSE_POL];
	wire logic pinCtlEn = control_reg[`CTL_AIRPLANE_PIN_EN];
	usb_mode_type usbMode;
	assign usbMode = usb_mode_type'(control_reg[`CTL_USB_MODE_MSB:`CTL_USB_MODE_LSB]);

	// Write channel: address and data taken in either order, response after both
	// Readies stay low while a response waits, so one write is in flight at most
	assign s_axi_awready = !awTaken && !s_axi_bvalid && !powerDown;
	assign s_axi_wready = !wTaken && !s_axi_bvalid && !powerDown;
	assign doWrite = awTaken && wTaken && !s_axi_bvalid;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			awTaken <= 1'b0;
			wTaken <= 1'b0;
			awAddr_reg <= 12'h000;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awTaken <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wTaken <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awTaken <= 1'b0;
				wTaken <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (regSel(awAddr_reg) == SEL_NONE) ? 2'b10 : 2'b00;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Per-register write strobes, decoded once from the captured address
	logic ctlWrite, funWrite, cmdWrite;
	assign ctlWrite = doWrite && (regSel(awAddr_reg) == SEL_CONTROL);
	assign funWrite = doWrite && (regSel(awAddr_reg) == SEL_FUNLEVEL);
	assign cmdWrite = doWrite && (regSel(awAddr_reg) == SEL_COMMAND) && wStrb_reg[0];

	// Control and functionality level registers
	logic [31:0] funMerged;
	assign funMerged = merge({29'h0, funLevel_reg}, wData_reg, wStrb_reg);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			control_reg <= `CTL_RESET; // Sleep disabled, pin ignored
			funLevel_reg <= `FUN_FULL; // Full function after start
		end else begin
			if (ctlWrite) begin
				control_reg <= merge(control_reg, wData_reg, wStrb_reg) & 32'h0000_001F;
			end
			if (funWrite && legalLevel(funMerged[2:0])) begin
				funLevel_reg <= funMerged[2:0]; // Other levels are ignored
			end
		end
	end

	// Effective level: the enabled pin, active low, forces airplane mode
	// Level zero stays minimal: the pin only narrows full function
	logic airplanePinActive;
	logic [2:0] effLevel;
	assign airplanePinActive = pinCtlEn && !pinStable.airplanePin;
	assign effLevel = (airplanePinActive && funLevel_reg == `FUN_FULL) ? `FUN_AIRPLANE :
		funLevel_reg;

	// Function enables from the level
	always_comb begin
		funcEnables.rfOn = (effLevel == `FUN_FULL);
		funcEnables.cardOn = (effLevel != `FUN_MIN);
		funcEnables.positionOn = !powerDown; // Level never touches this
	end

	// RF dependent command check: a write of 1 to bit 0 of the command register
	// is an RF command; refused while RF is off. Set wins over clear.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmdReject_reg <= 1'b0;
		end else if (cmdWrite && wData_reg[0] && !funcEnables.rfOn) begin
			cmdReject_reg <= 1'b1;
		end else if (cmdWrite && wData_reg[1]) begin
			cmdReject_reg <= 1'b0;
		end
	end

	// Host sleep sense with selectable active level
	logic hostAsleep;
	assign hostAsleep = (pinStable.hostSense == sensePol);

	// Sleep preconditions, evaluated every cycle
	// Mode three lets switched bus power stand in for a suspended bus
	logic usbReady, sleepOk, wakeEvent;
	always_comb begin
		case (usbMode)
			USB_REMOTE_WAKE, USB_RING_WAKE: usbReady = usbSuspended;
			USB_NO_SUSPEND: usbReady = !pinStable.usbPower;
			default: usbReady = 1'b1;
		endcase
	end
	assign sleepOk = sleepEn && pinStable.termReady && usbReady
		&& !powerDown;
	assign wakeEvent = !pinStable.termReady || usbRxData;

	// Sleep state machine; settle avoids bouncing on brief suspends
	// Any failing condition sends the machine back awake on the next edge
	pm_state_type pmState;
	logic [15:0] settleCnt;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pmState <= PM_AWAKE;
			settleCnt <= 16'h0000;
		end else begin
			case (pmState)
				PM_AWAKE: begin
					settleCnt <= 16'h0000;
					if (sleepOk && !wakeEvent) begin
						pmState <= PM_SETTLE;
					end
				end
				PM_SETTLE: begin
					if (!sleepOk || wakeEvent) begin
						pmState <= PM_AWAKE;
					end else if (settleCnt == SETTLE_CYC - 16'h0001) begin
						pmState <= PM_ASLEEP;
					end else begin
						settleCnt <= settleCnt + 16'h0001;
					end
				end
				PM_ASLEEP: begin
					if (!sleepOk || wakeEvent) begin
						pmState <= PM_AWAKE;
					end
				end
				default: pmState <= PM_AWAKE;
			endcase
		end
	end
	assign asleep = (pmState == PM_ASLEEP);
	assign networkAccept = networkEvent && !powerDown; // Asleep or not

	// Host wake: ring pulse or remote wakeup for a pending report
	// The pulse runs its full length even if the report is withdrawn early
	logic [15:0] ringCnt;
	logic usesRing;
	assign usesRing = (usbMode != USB_REMOTE_WAKE);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ringCnt <= 16'h0000;
			ringIndicator <= 1'b0;
			usbRemoteWake <= 1'b0;
		end else begin
			usbRemoteWake <= reportPending && hostAsleep && !usesRing && !powerDown;
			if (ringCnt != 16'h0000) begin
				ringCnt <= ringCnt - 16'h0001;
				ringIndicator <= 1'b1;
			end else if (reportPending && hostAsleep && usesRing && !ringIndicator
					&& !powerDown) begin
				ringCnt <= RING_CYC - 16'h0001;
				ringIndicator <= 1'b1;
			end else begin
				ringIndicator <= 1'b0;
			end
		end
	end

	// Status word
	// Snapshot taken at the read address edge, not at the data edge
	logic [31:0] statusWord;
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`ST_ASLEEP] = asleep;
		statusWord[`ST_RF_ON] = funcEnables.rfOn;
		statusWord[`ST_CARD_ON] = funcEnables.cardOn;
		statusWord[`ST_HOST_ASLEEP] = hostAsleep;
		statusWord[`ST_RING] = ringIndicator;
		statusWord[`ST_REMOTE_WAKE] = usbRemoteWake;
		statusWord[`ST_CMD_REJECT] = cmdReject_reg;
		statusWord[`ST_POSITION_ON] = funcEnables.positionOn;
	end

	// Read channel: one cycle to answer, unmapped gives slave error (2'b10)
	// Power down drops the readies, so the bus gets no answer at all
	assign s_axi_arready = !s_axi_rvalid && !powerDown;
	assign s_axi_rdata = rdata_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			rdata_reg <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (regSel(s_axi_araddr))
				SEL_CONTROL: rdata_reg <= control_reg;
				SEL_FUNLEVEL: rdata_reg <= {29'h0, effLevel};
				SEL_STATUS: rdata_reg <= statusWord;
				SEL_SUPPLY: rdata_reg <= 32'(baseband_supply);
				SEL_COMMAND: rdata_reg <= {31'h0, cmdReject_reg};
				SEL_ID: rdata_reg <= ID_VALUE;
				default: begin
					rdata_reg <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

//--- sleep_airplane_mode_control_sva.sv
// Port checker for the sleep and airplane mode controller.
// Assumes one clock domain and the package pin and enable structs.
`timescale 1ns/1ns
module sleep_airplane_sva (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_arready,
	input wire sleep_airplane_pkg::pin_inputs_type pinsIn,
	input wire logic usbRxData,
	input wire logic reportPending,
	input wire logic powerDown,
	input wire logic networkEvent,
	input wire logic ringIndicator,
	input wire logic usbRemoteWake,
	input wire logic asleep,
	input wire logic networkAccept,
	input wire sleep_airplane_pkg::func_enables_type funcEnables
);
	import sleep_airplane_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// Saturating count of awake cycles, to time the settle span before sleep
	logic [7:0] awakeCnt;
	always_ff @(posedge sys_clk) begin
		if (srst || asleep) begin
			awakeCnt <= 8'h00;
		end else if (awakeCnt != 8'hFF) begin
			awakeCnt <= awakeCnt + 8'h01;
		end
	end
	// Network traffic is only cut by power down
	property p_net; networkAccept == (networkEvent && !powerDown); endproperty
	a_net: assert property (p_net) else $error("network accept wrong");
	// No bus access while powered down
	property p_pd; powerDown |-> !s_axi_awready && !s_axi_wready && !s_axi_arready; endproperty
	a_pd: assert property (p_pd) else $error("bus ready in power down");
	// Positioning never follows the level
	property p_pos; funcEnables.positionOn == !powerDown; endproperty
	a_pos: assert property (p_pos) else $error("positioning changed");
	// No level leaves RF on with the card off
	property p_card; !funcEnables.cardOn |-> !funcEnables.rfOn; endproperty
	a_card: assert property (p_card) else $error("rf on with card off");
	// Low terminal ready must wake within the synchroniser delay
	property p_term; !pinsIn.termReady [*6] |-> !asleep; endproperty
	a_term: assert property (p_term) else $error("no wake on terminal ready");
	// USB data wakes on the next edge
	property p_usb; usbRxData |=> !asleep; endproperty
	a_usb: assert property (p_usb) else $error("no wake on usb data");
	// Ring only starts for a waiting report
	property p_ring; $rose(ringIndicator) |-> $past(reportPending); endproperty
	a_ring: assert property (p_ring) else $error("ring without report");
	// Remote wakeup only for a waiting report
	property p_rw; usbRemoteWake |-> $past(reportPending); endproperty
	a_rw: assert property (p_rw) else $error("remote wake without report");
	// Sleep needs the settle span awake first
	property p_settle; $rose(asleep) |-> awakeCnt >= 8'hC8; endproperty
	a_settle: assert property (p_settle) else $error("sleep entered too soon");
endmodule
bind sleep_airplane_mode_control sleep_airplane_sva chk (.*);

//--- host_model.sv
// Host processor model that drives the controller's pin inputs.
// Assumes the bench states the host's intent as plain levels.
`timescale 1ns/1ns
module host_model (
	input wire logic hostSleeping,
	input wire logic wakeDevice,
	input wire logic vbusOn,
	input wire logic rfKill,
	output sleep_airplane_pkg::pin_inputs_type pins
);
	import sleep_airplane_pkg::*;
	// Terminal ready held high unless the host wants the device awake
	assign pins.termReady = !wakeDevice;
	assign pins.hostSense = !hostSleeping; // Low means asleep
	assign pins.usbPower = vbusOn; // Externally switched
	assign pins.airplanePin = !rfKill; // Active low
endmodule

//--- sleep_airplane_mode_control_tb.sv
// Self-checking bench for the sleep and airplane mode controller.
// Assumes the params header, the package and the host model.
`timescale 1ns/1ns
`include "sleep_airplane_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module sleep_airplane_mode_control_tb;
	import sleep_airplane_pkg::*;
	logic sys_clk = 0, srst = 1;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, baseband_supply = 12'hABC;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic usbSuspended = 0, usbRxData = 0, reportPending = 0, powerDown = 0, networkEvent = 0;
	logic hostSleeping = 0, wakeDevice = 0, vbusOn = 1, rfKill = 0;
	logic ringIndicator, usbRemoteWake, asleep, networkAccept;
	func_enables_type funcEnables;
	pin_inputs_type pinsIn;
	int fails = 0, samples_checked = 0;
	logic [1:0] lastBresp = 2'b00;
	localparam logic [31:0] ID_EXP = 32'h0000_C3C3; // Arbitrary value
	sleep_airplane_mode_control #(.ID_VALUE(ID_EXP)) dut (.*);
	host_model host (.hostSleeping, .wakeDevice, .vbusOn, .rfKill, .pins(pinsIn));
	always #25 sys_clk = ~sys_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Write: both channels offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		lastBresp = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge sys_clk); // Idle edge, so a next call never re-raises bready at once
	endtask
	// Read and compare data and response
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, r)
		@(posedge sys_clk); // Idle edge, so a next call never re-raises rready at once
	endtask
	task automatic done(input string s);
		$display("test %s ended", s);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Run far longer than the tests need, then give up
	initial begin
		#(20000 * 50);
		fails++;
		give_verdict();
	end
	// Main sequence
	initial begin
		tick(6);
		srst <= 0;
		tick(1);
		rdc(`OFS_FUNLEVEL, 1, 0);
		rdc(`OFS_STATUS, 32'h86, 0);
		wr(12'h020, 32'h0000_0001);
		`CHK(lastBresp, 2'b10)
		rdc(`OFS_CONTROL, `CTL_RESET, 0);
		rdc(12'h020, 0, 2'b10);
		rdc(`OFS_ID, ID_EXP, 0);
		rdc(`OFS_SUPPLY, 32'hABC, 0);
		tick(260);
		`CHK(asleep, 0)
		done("reset");
		wr(`OFS_FUNLEVEL, 0);
		`CHK(lastBresp, 2'b00)
		tick(1);
		`CHK(funcEnables, 3'b001)
		wr(`OFS_FUNLEVEL, 4);
		tick(1);
		`CHK(funcEnables, 3'b011)
		wr(`OFS_COMMAND, 1);
		rdc(`OFS_STATUS, 32'hC4, 0);
		wr(`OFS_COMMAND, 2);
		rdc(`OFS_STATUS, 32'h84, 0);
		wr(`OFS_FUNLEVEL, 3);
		rdc(`OFS_FUNLEVEL, 4, 0);
		wr(`OFS_FUNLEVEL, 1);
		wr(`OFS_COMMAND, 1);
		rdc(`OFS_STATUS, 32'h86, 0);
		rfKill <= 1;
		tick(6);
		`CHK(funcEnables.rfOn, 1)
		wr(`OFS_CONTROL, 4);
		tick(6);
		`CHK(funcEnables.rfOn, 0)
		rfKill <= 0;
		done("levels");
		wr(`OFS_CONTROL, 1);
		tick(260);
		`CHK(asleep, 1)
		networkEvent <= 1;
		hostSleeping <= 1;
		reportPending <= 1;
		tick(8);
		`CHK(networkAccept, 1)
		`CHK(ringIndicator, 1)
		reportPending <= 0;
		hostSleeping <= 0;
		wakeDevice <= 1;
		tick(6);
		`CHK(asleep, 0)
		wakeDevice <= 0;
		done("uart");
		wr(`OFS_CONTROL, 32'h9);
		tick(260);
		`CHK(asleep, 0)
		usbSuspended <= 1;
		tick(260);
		`CHK(asleep, 1)
		usbRxData <= 1;
		tick(1);
		usbRxData <= 0;
		tick(1);
		`CHK(asleep, 0)
		hostSleeping <= 1;
		reportPending <= 1;
		wr(`OFS_CONTROL, 32'hA);
		tick(8);
		`CHK(usbRemoteWake, 0)
		wr(`OFS_CONTROL, 32'h9);
		tick(8);
		`CHK(usbRemoteWake, 1)
		wr(`OFS_CONTROL, 32'h11);
		tick(8);
		`CHK(usbRemoteWake, 0)
		tick(260);
		`CHK(asleep, 1)
		reportPending <= 0;
		hostSleeping <= 0;
		usbSuspended <= 0;
		tick(2);
		`CHK(asleep, 0)
		done("usb");
		wr(`OFS_CONTROL, 32'h19);
		tick(260);
		`CHK(asleep, 0)
		vbusOn <= 0;
		tick(260);
		`CHK(asleep, 1)
		vbusOn <= 1;
		tick(6);
		`CHK(asleep, 0)
		powerDown <= 1;
		tick(2);
		`CHK(s_axi_arready, 0)
		`CHK(networkAccept, 0)
		`CHK(funcEnables.positionOn, 0)
		powerDown <= 0;
		networkEvent <= 0;
		done("power");
		give_verdict();
	end
endmodule
